// ---- hdl/civi_intercept.sv ----
// top: io and video intercept, nmi generation, cause port emulation
`timescale 1ns/1ns
// Behaviour
// - write A2h arms io trap, A3h disarms
// - flag unsupported io ports from map
// - nmi on armed io trap and strobe of an unsupported port
// - track instruction type every instruction
// - nmi freezes tracker, latches address/type
// - store address 0..13 plus two-bit type
// - write A0h arms video trap, A1h disarms
// - nmi on armed video page write
// - remap enable via control write, reset clears
// - remap hit on B000h page when enabled
// - drive ram bits 14..18, select source
// - remapped local write forces bits 15..18
// - upper bits stable at column strobe fall
// - nmi on coprocessor fault
// - cause port bit 6 reads zero
// - cause port bit 7 shows coprocessor interrupt
module civi_intercept import civi_pkg::*; #(
  parameter logic [15:0] IO_MAP_MASK = 16'h03FF
) (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire civi_bus_t bus_i,
  input wire logic [7:0] io_wdata_i,
  input wire logic port_supported_i,
  input wire logic fpu_int_i,
  input wire logic [4:0] host_upper_i,
  input wire logic host_owns_ram_i,
  output logic nmi_o,
  output logic [7:0] io_rdata_o,
  output logic io_rdata_valid_o,
  output logic unsupported_io_address_o,
  output logic video_remap_hit_o,
  output logic [4:0] ram_upper_address_o
);
  logic fpu_meta_r;
  logic fpu_sync_r;
  logic io_trap_enable_r;
  logic video_trap_enable_r;
  logic video_remap_enable_r;
  civi_trap_t trap_w;
  logic [15:0] port;
  logic io_any;
  logic wr_io;
  logic io_nmi;
  logic vid_nmi;
  logic in_video_page;
  logic [7:0] rdata_nxt;
  logic rsel;

  function automatic logic civi_wr(input civi_bus_t b, input logic [15:0] p);
    civi_wr = b.io_write_strobe && (b.addr[15:0] == p);
  endfunction

  assign port = bus_i.addr[15:0];
  assign io_any = bus_i.io_read_strobe | bus_i.io_write_strobe;
  assign wr_io = bus_i.io_write_strobe;
  assign unsupported_io_address_o = io_any && ((port & ~IO_MAP_MASK) == '0) && !port_supported_i;
  assign io_nmi = io_trap_enable_r && unsupported_io_address_o && io_any;
  assign in_video_page = bus_i.addr[19:16] == CIVI_VIDEO_PAGE;
  assign vid_nmi = video_trap_enable_r && bus_i.memory_write_strobe && in_video_page;
  assign nmi_o = io_nmi | vid_nmi | fpu_sync_r;
  assign video_remap_hit_o = in_video_page && video_remap_enable_r;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      fpu_meta_r <= 1'b0;
      fpu_sync_r <= 1'b0;
    end else begin
      fpu_meta_r <= fpu_int_i;
      fpu_sync_r <= fpu_meta_r;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      io_trap_enable_r <= CIVI_ENABLE_RESET;
      video_trap_enable_r <= CIVI_ENABLE_RESET;
      video_remap_enable_r <= CIVI_ENABLE_RESET;
    end else begin
      if (civi_wr(bus_i, CIVI_PORT_IO_SET)) begin
        io_trap_enable_r <= 1'b1;
      end else if (civi_wr(bus_i, CIVI_PORT_IO_CLR)) begin
        io_trap_enable_r <= 1'b0;
      end
      if (civi_wr(bus_i, CIVI_PORT_VID_SET)) begin
        video_trap_enable_r <= 1'b1;
      end else if (civi_wr(bus_i, CIVI_PORT_VID_CLR)) begin
        video_trap_enable_r <= 1'b0;
      end
      if (civi_wr(bus_i, CIVI_PORT_SYS_CTRL)) begin
        video_remap_enable_r <= io_wdata_i[CIVI_REMAP_EN_BIT];
      end
    end
  end

  civi_tracker u_tracker (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .bus_i(bus_i),
    .freeze_i(nmi_o),
    .trap_o(trap_w)
  );

  civi_translate u_translate (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .cpu_upper_i(bus_i.addr[18:14]),
    .host_upper_i(host_upper_i),
    .host_owns_ram_i(host_owns_ram_i),
    .cpu_ram_write_i(bus_i.memory_write_strobe && !host_owns_ram_i),
    .video_remap_hit_i(video_remap_hit_o),
    .ram_upper_address_o(ram_upper_address_o)
  );

  // read-back mux for cause and trap latches
  always_comb begin
    rdata_nxt = 8'h00;
    rsel = bus_i.io_read_strobe;
    if (port == CIVI_PORT_CAUSE) begin
      rdata_nxt[CIVI_CAUSE_CHK_BIT] = 1'b0;
      rdata_nxt[CIVI_CAUSE_FPU_BIT] = fpu_sync_r;
    end else if (port == CIVI_PORT_TRAP_LO) begin
      rdata_nxt = trap_w.addr[7:0];
    end else if (port == CIVI_PORT_TRAP_HI) begin
      rdata_nxt = {trap_w.itype, trap_w.addr[13:8]};
    end else begin
      rsel = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      io_rdata_o <= 8'h00;
      io_rdata_valid_o <= 1'b0;
    end else begin
      io_rdata_o <= rdata_nxt;
      io_rdata_valid_o <= rsel;
    end
  end
endmodule // civi_intercept

// ---- hdl/civi_pkg.sv ----
// package: constants and carriers for the cpu io/video intercept block
package civi_pkg;
  localparam logic [15:0] CIVI_PORT_VID_SET = 16'h00A0;
  localparam logic [15:0] CIVI_PORT_VID_CLR = 16'h00A1;
  localparam logic [15:0] CIVI_PORT_IO_SET = 16'h00A2;
  localparam logic [15:0] CIVI_PORT_IO_CLR = 16'h00A3;
  localparam logic [15:0] CIVI_PORT_CAUSE = 16'h0062;
  localparam logic [15:0] CIVI_PORT_TRAP_LO = 16'h00A4;
  localparam logic [15:0] CIVI_PORT_TRAP_HI = 16'h00A5;
  localparam logic [15:0] CIVI_PORT_SYS_CTRL = 16'h00A6;
  localparam int CIVI_CAUSE_CHK_BIT = 6;
  localparam int CIVI_CAUSE_FPU_BIT = 7;
  localparam int CIVI_REMAP_EN_BIT = 0;
  localparam logic [3:0] CIVI_VIDEO_PAGE = 4'hB;
  localparam logic [3:0] CIVI_REMAP_FORCE = 4'hF;
  localparam logic [1:0] CIVI_TYPE_NONE = 2'h0;
  localparam logic [1:0] CIVI_TYPE_IN = 2'h1;
  localparam logic [1:0] CIVI_TYPE_OUT = 2'h2;
  localparam logic [1:0] CIVI_TYPE_MEM = 2'h3;
  localparam logic CIVI_ENABLE_RESET = 1'b0;

  typedef struct packed {
    logic [19:0] addr;
    logic io_read_strobe;
    logic io_write_strobe;
    logic memory_read_strobe;
    logic memory_write_strobe;
  } civi_bus_t;

  typedef struct packed {
    logic [13:0] addr;
    logic [1:0] itype;
  } civi_trap_t;
endpackage

// ---- hdl/civi_tracker.sv ----
// instruction type tracker with freeze and trap latches
`timescale 1ns/1ns
module civi_tracker import civi_pkg::*; (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire civi_bus_t bus_i,
  input wire logic freeze_i,
  output civi_trap_t trap_o
);
  typedef enum logic [1:0] {civi_trk_idle, civi_trk_in, civi_trk_out, civi_trk_mem} civi_trk_t;
  civi_trk_t state_r;
  civi_trk_t state_nxt;
  logic frozen_r;
  logic any_cycle;
  assign any_cycle = bus_i.io_read_strobe | bus_i.io_write_strobe | bus_i.memory_read_strobe
                     | bus_i.memory_write_strobe;
  always_comb begin
    state_nxt = state_r;
    if (bus_i.io_read_strobe) begin
      state_nxt = civi_trk_in;
    end else if (bus_i.io_write_strobe) begin
      state_nxt = civi_trk_out;
    end else if (any_cycle) begin
      state_nxt = civi_trk_mem;
    end
  end
  function automatic logic [1:0] civi_code(input civi_trk_t s);
    unique case (s)
      civi_trk_idle: civi_code = CIVI_TYPE_NONE;
      civi_trk_in: civi_code = CIVI_TYPE_IN;
      civi_trk_out: civi_code = CIVI_TYPE_OUT;
      civi_trk_mem: civi_code = CIVI_TYPE_MEM;
    endcase
  endfunction
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      state_r <= civi_trk_idle;
      frozen_r <= 1'b0;
      trap_o <= '0;
    end else begin
      frozen_r <= freeze_i;
      if (!freeze_i) begin
        state_r <= state_nxt;
      end
      if (freeze_i && !frozen_r) begin
        trap_o <= '{addr: bus_i.addr[13:0], itype: civi_code(state_nxt)};
      end
    end
  end
endmodule // civi_tracker

// ---- hdl/civi_translate.sv ----
// ram upper address translator with video remap
`timescale 1ns/1ns
module civi_translate import civi_pkg::*; (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic [4:0] cpu_upper_i,
  input wire logic [4:0] host_upper_i,
  input wire logic host_owns_ram_i,
  input wire logic cpu_ram_write_i,
  input wire logic video_remap_hit_i,
  output logic [4:0] ram_upper_address_o
);
  logic [4:0] local_sel;
  logic [4:0] addr_nxt;
  assign local_sel = (cpu_ram_write_i && video_remap_hit_i) ? {CIVI_REMAP_FORCE, cpu_upper_i[0]} : cpu_upper_i;
  assign addr_nxt = host_owns_ram_i ? host_upper_i : local_sel;
  // registered so bits are stable before column strobe falls
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      ram_upper_address_o <= '0;
    end else begin
      ram_upper_address_o <= addr_nxt;
    end
  end
endmodule // civi_translate

// ---- verification/civi_cpu_model.sv ----
// behavioural local processor bus master
`timescale 1ns/1ns
module civi_cpu_model import civi_pkg::*; (
  input wire logic clk_sys_i,
  input wire logic nmi_i,
  input wire logic [7:0] rdata_i,
  input wire logic rvalid_i,
  output civi_bus_t bus_o,
  output logic [7:0] wdata_o
);
  initial begin
    bus_o = '0;
    wdata_o = 8'h00;
  end
  // one strobed edge, then lines float to inverted values
  task cyc(input logic [3:0] st, input logic [19:0] a, input logic [7:0] d, output logic n, output logic [8:0] r);
    @(negedge clk_sys_i);
    bus_o <= {a, st};
    wdata_o <= d;
    @(negedge clk_sys_i);
    n = nmi_i;
    r = {rvalid_i, rdata_i};
    bus_o <= {~a, 4'h0};
    wdata_o <= ~d;
  endtask
endmodule // civi_cpu_model

// ---- verification/civi_intercept_assertions.sv ----
// checker: port-level assertions for the intercept top
`timescale 1ns/1ns
module civi_intercept_assertions import civi_pkg::*; (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire civi_bus_t bus_i,
  input wire logic port_supported_i,
  input wire logic fpu_int_i,
  input wire logic [4:0] host_upper_i,
  input wire logic host_owns_ram_i,
  input wire logic nmi_o,
  input wire logic [7:0] io_rdata_o,
  input wire logic unsupported_io_address_o,
  input wire logic video_remap_hit_o,
  input wire logic [4:0] ram_upper_address_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  wire logic rd62 = bus_i.io_read_strobe && bus_i.addr[15:0] == 16'h0062;
  wire logic wr_io = bus_i.io_write_strobe && bus_i.addr[15:0] == 16'h00A2;
  wire logic wr_vid = bus_i.io_write_strobe && bus_i.addr[15:0] == 16'h00A0;
  wire logic vid_wr = bus_i.memory_write_strobe && bus_i.addr[19:16] == 4'hB;
  wire logic io_clr = bus_i.io_write_strobe && bus_i.addr[15:0] == 16'h00A3;
  wire logic vid_clr = bus_i.io_write_strobe && bus_i.addr[15:0] == 16'h00A1;
  AST_CHK_ZERO: assert property (rd62 |=> !io_rdata_o[6]) else $error("cause bit 6 set");
  AST_FPU_BIT: assert property (rd62 && $past(rst_b_i) && $past(fpu_int_i, 2) && $past(rst_b_i, 2)
    |=> io_rdata_o[7]) else $error("cause bit 7 low");
  AST_FPU_NMI: assert property ($past(rst_b_i) && $past(fpu_int_i, 2) && $past(rst_b_i, 2) |-> nmi_o)
    else $error("no fpu nmi");
  AST_UNSUP: assert property (bus_i.io_read_strobe && !port_supported_i && bus_i.addr[15:10] == 6'h00
    |-> unsupported_io_address_o) else $error("no unsupported flag");
  AST_IO_NMI: assert property (wr_io ##1 !io_clr ##1 unsupported_io_address_o |-> nmi_o)
    else $error("no io nmi");
  AST_VID_NMI: assert property (wr_vid ##1 !vid_clr ##1 vid_wr |-> nmi_o)
    else $error("no video nmi");
  AST_HIT_PAGE: assert property (video_remap_hit_o |-> bus_i.addr[19:16] == 4'hB) else $error("bad hit");
  AST_FORCE: assert property (vid_wr && video_remap_hit_o && !host_owns_ram_i
    |=> ram_upper_address_o[4:1] == 4'hF) else $error("remap not forced");
  AST_HOST_SEL: assert property (host_owns_ram_i |=> ram_upper_address_o == $past(host_upper_i))
    else $error("host address not selected");
  AST_RST_CLR: assert property (!$past(rst_b_i) |-> !nmi_o && !video_remap_hit_o)
    else $error("enable survived reset");
  COV_IO: cover property (wr_io ##2 unsupported_io_address_o);
  COV_VID: cover property (vid_wr && nmi_o);
  COV_MAP: cover property (video_remap_hit_o);
endmodule // civi_intercept_assertions

// ---- verification/civi_intercept_test.sv ----
// self-checking bench for the intercept top
`timescale 1ns/1ns
module civi_intercept_test;
  logic clk_sys_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic port_supported_i = 1'b1;
  logic fpu_int_i = 1'b0;
  logic host_owns_ram_i = 1'b0;
  logic [4:0] host_upper_i = 5'h15;
  civi_pkg::civi_bus_t bus_i;
  logic [7:0] io_wdata_i, io_rdata_o;
  logic [4:0] ram_upper_address_o;
  logic nmi_o, io_rdata_valid_o, unsupported_io_address_o, video_remap_hit_o, n;
  logic [8:0] r;
  int fail_count = 0;
  int total_checks = 0;
  initial begin
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  civi_intercept u_civi_intercept(.clk_sys_i, .rst_b_i, .bus_i, .io_wdata_i, .port_supported_i, .fpu_int_i,
    .host_upper_i, .host_owns_ram_i, .nmi_o, .io_rdata_o, .io_rdata_valid_o, .unsupported_io_address_o,
    .video_remap_hit_o, .ram_upper_address_o);
  civi_cpu_model u_civi_cpu_model(.clk_sys_i, .nmi_i(nmi_o), .rdata_i(io_rdata_o), .rvalid_i(io_rdata_valid_o),
    .bus_o(bus_i), .wdata_o(io_wdata_i));
  task check(input logic [8:0] seen, input logic [8:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task cyc(input logic [3:0] st, input logic [19:0] a, input logic [7:0] d);
    u_civi_cpu_model.cyc(st, a, d, n, r);
  endtask
  task do_reset;
    @(negedge clk_sys_i);
    rst_b_i = 1'b0;
    repeat (16) @(negedge clk_sys_i);
    rst_b_i = 1'b1;
  endtask
  task t_io_trap;
    port_supported_i = 1'b0;
    cyc(4'h8, 20'h003F8, 8'h00);
    check(n, 1'b0);
    check(unsupported_io_address_o, 1'b1);
    cyc(4'h4, 20'h000A2, 8'h00);
    for (int i = 0; i < 2; i++) begin
      port_supported_i = 1'b0;
      cyc(i ? 4'h4 : 4'h8, 20'h003F8, 8'h5A);
      check(n, 1'b1);
      check(unsupported_io_address_o, 1'b1);
      port_supported_i = 1'b1;
      cyc(4'h8, 20'h000A4, 8'h00);
      check(r, 9'h1F8);
      check(unsupported_io_address_o, 1'b0);
      cyc(4'h8, 20'h000A5, 8'h00);
      check(r, i ? 9'h183 : 9'h143);
    end
    cyc(4'h4, 20'h000A3, 8'h00);
    port_supported_i = 1'b0;
    cyc(4'h8, 20'h003F8, 8'h00);
    check(n, 1'b0);
    check(unsupported_io_address_o, 1'b1);
    cyc(4'h8, 20'h00400, 8'h00);
    check(unsupported_io_address_o, 1'b0);
    port_supported_i = 1'b1;
  endtask
  task t_video;
    cyc(4'h4, 20'h000A0, 8'h00);
    cyc(4'h1, 20'hB0123, 8'h00);
    check(n, 1'b1);
    cyc(4'h8, 20'h000A4, 8'h00);
    check(r, 9'h123);
    cyc(4'h8, 20'h000A5, 8'h00);
    check(r, 9'h1C1);
    cyc(4'h1, 20'hA0123, 8'h00);
    check(n, 1'b0);
    cyc(4'h4, 20'h000A1, 8'h00);
    cyc(4'h1, 20'hB0123, 8'h00);
    check(n, 1'b0);
  endtask
  task t_fpu;
    cyc(4'h8, 20'h00062, 8'h00);
    check(r[8:6], 3'h4);
    fpu_int_i = 1'b1;
    repeat (3) @(negedge clk_sys_i);
    check(nmi_o, 1'b1);
    cyc(4'h8, 20'h00062, 8'h00);
    check(r[8:6], 3'h6);
    fpu_int_i = 1'b0;
  endtask
  task t_remap;
    cyc(4'h1, 20'hB4000, 8'h00);
    check(video_remap_hit_o, 1'b0);
    check(ram_upper_address_o, 5'h0D);
    cyc(4'h4, 20'h000A6, 8'h01);
    cyc(4'h1, 20'hB4000, 8'h00);
    check(video_remap_hit_o, 1'b1);
    check(ram_upper_address_o, 5'h1F);
    cyc(4'h2, 20'hB4000, 8'h00);
    check(video_remap_hit_o, 1'b1);
    check(ram_upper_address_o, 5'h0D);
    host_owns_ram_i = 1'b1;
    cyc(4'h1, 20'hB4000, 8'h00);
    check(ram_upper_address_o, 5'h15);
    host_owns_ram_i = 1'b0;
    do_reset;
    cyc(4'h1, 20'hB4000, 8'h00);
    check(video_remap_hit_o, 1'b0);
  endtask
  initial begin
    do_reset;
    t_io_trap;
    t_video;
    t_fpu;
    t_remap;
    close_out;
  end
  initial begin
    #20000;
    fail_count++;
    close_out;
  end
endmodule // civi_intercept_test
bind civi_intercept civi_intercept_assertions u_civi_intercept_assertions(.clk_sys_i, .rst_b_i, .bus_i,
  .port_supported_i, .fpu_int_i, .host_upper_i, .host_owns_ram_i, .nmi_o, .io_rdata_o,
  .unsupported_io_address_o, .video_remap_hit_o, .ram_upper_address_o);
